//--- logic/ecs_serializer.v
`timescale 1ns/1ns
`include "ecs_consts.vh"
// Summary of operation
// - each word clock rising edge captures every channel's 10-bit word.
// - all channels share one word clock and one lock model.
// - master sleep low stops the pll and floats all outputs.
// - channel sleep low floats only that channel; pll stays locked.
// - nothing runs and outputs float until supply good is seen.
// - once locked, each channel sends data or sync per its request.
// - sync pattern is six ones then six zeros, once per word period.
// - request high for 4 word clocks replaces data with sync.
// - request low returns the channel to sending data.
// - frames carry a start bit of one and a stop bit of zero.
// - twelve frame bits leave within each word clock period.
// - data drives only with enable, both sleeps high, request not held for 4 word clocks.
// - drive enable low floats all eight outputs regardless.
// - drive enable returning high shows each channel's current state, as if it had never floated.
module ecs_serializer #(
    parameter CHANNELS  = `ECS_CHANNELS,
    parameter DATA_BITS = `ECS_DATA_BITS
) (
    input  wire                          clk,
    input  wire                          rstn,
    input  wire                          sharedWordClock,
    input  wire                          supplyGood,
    input  wire                          masterSleepN,
    input  wire [CHANNELS-1:0]           channelSleepN,
    input  wire                          outputDriveEnable,
    input  wire [CHANNELS-1:0]           resyncRequest,
    input  wire [CHANNELS*DATA_BITS-1:0] parallelWordIn,
    output wire [CHANNELS-1:0]           serialLineOut,
    output wire [CHANNELS-1:0]           serialLineOe,
    output wire                          pllLocked,
    output wire [CHANNELS-1:0]           channelAwake,
    output wire [CHANNELS-1:0]           syncActive
);

    // bits per frame, start and stop included
    localparam FRAME_BITS = `ECS_FRAME_BITS;

    // global power states of the device
    localparam [1:0] ST_OFF     = 2'b00;
    localparam [1:0] ST_ASLEEP  = 2'b01;
    localparam [1:0] ST_LOCKING = 2'b10;
    localparam [1:0] ST_RUN     = 2'b11;

    // synchronised copies of the pins
    wire                          wordClockSync;
    wire                          supplyGoodSync;
    wire                          masterSleepNSync;
    wire                          driveEnableSync;
    wire [CHANNELS-1:0]           channelSleepNSync;
    wire [CHANNELS-1:0]           resyncSync;
    wire [CHANNELS*DATA_BITS-1:0] wordSync;
    // shared timing and power state
    wire                          pllRun;
    wire                          lockDone;
    reg                           wordClockLast;
    reg  [1:0]                    powerState;
    reg  [1:0]                    next_powerState;
    wire                          wordEdge;
    wire                          runState;

    // latency from any pin to the line: two synchroniser flops and one
    // registered decision, so outputs move three clocks after a pin
    // all control pins are asynchronous to clk and pass two flops
    ecs_sync2 #(
        .WIDTH (4)
    ) uCtrlSync (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   ({sharedWordClock, supplyGood, masterSleepN,
                   outputDriveEnable}),
        .syncOut ({wordClockSync, supplyGoodSync, masterSleepNSync,
                   driveEnableSync})
    );

    // per-channel control pins
    ecs_sync2 #(
        .WIDTH (2*CHANNELS)
    ) uChanSync (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   ({channelSleepN, resyncRequest}),
        .syncOut ({channelSleepNSync, resyncSync})
    );

    // the data bus takes the same two-flop path as the word clock, so a
    // word lines up with the clock edge that launched it
    ecs_sync2 #(
        .WIDTH (CHANNELS*DATA_BITS)
    ) uWordSync (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   (parallelWordIn),
        .syncOut (wordSync)
    );

    // the word clock is treated as data: its edge is found on clk
    // rising edge finder reads only the second synchroniser stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wordClockLast <= 1'b0;
        end else begin
            wordClockLast <= wordClockSync;
        end
    end

    assign wordEdge = wordClockSync & ~wordClockLast;

    // the pll runs only with supply good and master sleep released
    assign pllRun = supplyGoodSync & masterSleepNSync;

    // one shared lock model for every channel; losing power restarts it
    ecs_lock_timer #(
        .CNT_W      (`ECS_PLL_CNT_W),
        .LOCK_EDGES (`ECS_PLL_LOCK_EDGES)
    ) uPllLock (
        .clk      (clk),
        .rstn     (rstn),
        .enable   (pllRun),
        .wordEdge (wordEdge),
        .locked   (lockDone)
    );

    // power state follows supply, master sleep and lock
    always @* begin
        next_powerState = powerState;
        case (powerState)
            // no supply: everything held off
            ST_OFF: begin
                if (supplyGoodSync) begin
                    next_powerState = ST_ASLEEP;
                end
            end
            // supply good, waiting for master sleep to release
            ST_ASLEEP: begin
                if (!supplyGoodSync) begin
                    next_powerState = ST_OFF;
                end else if (masterSleepNSync) begin
                    next_powerState = ST_LOCKING;
                end
            end
            // lock timer running; outputs still float
            ST_LOCKING: begin
                if (!pllRun) begin
                    next_powerState = supplyGoodSync ? ST_ASLEEP : ST_OFF;
                end else if (lockDone) begin
                    next_powerState = ST_RUN;
                end
            end
            // locked: channels may drive
            ST_RUN: begin
                if (!pllRun) begin
                    next_powerState = supplyGoodSync ? ST_ASLEEP : ST_OFF;
                end
            end
            // an unused code falls back to the safe off state
            default: begin
                next_powerState = ST_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            powerState <= ST_OFF;
        end else begin
            powerState <= next_powerState;
        end
    end

    // run state gates every channel's drive; pllLocked is the state
    // itself, so it drops in the same clock as the state
    assign runState  = (powerState == ST_RUN);
    assign pllLocked = runState;

    // one serializer per channel, all paced by the shared word edge
    // channels are independent; only word edge, power, lock and drive enable are shared
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
            // sync request tracking
            reg  [`ECS_SYNC_CNT_W-1:0] syncCount;
            reg                        syncMode;
            // serial output stage
            reg  [FRAME_BITS-1:0]      shiftReg;
            reg                        lineBit;
            reg                        lineOe;
            reg  [FRAME_BITS-1:0]      next_frame;
            wire                       chanWake;
            wire                       chanOn;
            wire [DATA_BITS-1:0]       chanWord;
            wire                       syncLoad;
            wire                       driveOk;

            // this channel's slice of the synchronised data bus
            assign chanWord = wordSync[ch*DATA_BITS +: DATA_BITS];

            // a channel runs only while the pll runs and its own sleep
            // is released; its sleep leaves the shared lock untouched
            assign chanOn = pllRun & channelSleepNSync[ch];

            // the channel wake delay hides the driver start-up after sleep
            ecs_lock_timer #(
                .CNT_W      (`ECS_PLL_CNT_W),
                .LOCK_EDGES (`ECS_CH_WAKE_EDGES)
            ) uWake (
                .clk      (clk),
                .rstn     (rstn),
                .enable   (chanOn),
                .wordEdge (wordEdge),
                .locked   (chanWake)
            );

            // sync mode needs the request seen on four word edges in a
            // row; dropping the request leaves sync at once
            // a pulse of three words or less never reaches sync
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    syncCount <= {`ECS_SYNC_CNT_W{1'b0}};
                    syncMode  <= 1'b0;
                end else if (!resyncSync[ch] || !chanOn) begin
                    syncCount <= {`ECS_SYNC_CNT_W{1'b0}};
                    syncMode  <= 1'b0;
                end else if (wordEdge) begin
                    if (syncCount == `ECS_SYNC_HOLD_EDGES - 1'b1) begin
                        syncMode <= 1'b1;
                    end
                    if (syncCount != `ECS_SYNC_HOLD_EDGES) begin
                        syncCount <= syncCount + 1'b1;
                    end
                end
            end

            // the fourth request edge already carries the sync pattern
            assign syncLoad = wordEdge & resyncSync[ch] &
                              (syncCount ==
                               `ECS_SYNC_HOLD_EDGES - 1'b1);

            // frame for the next word period, sent lsb first
            always @* begin
                next_frame = {`ECS_STOP_LEVEL, chanWord,
                              `ECS_START_LEVEL};
                if (syncMode || syncLoad) begin
                    next_frame = `ECS_SYNC_PATTERN;
                end
            end

            // clk is the bit clock, twelve per word period: each word
            // edge reloads the frame, other cycles shift one bit out;
            // after the last bit the line rests at the stop level
            // a word edge that comes early cuts the frame short
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    shiftReg <= {FRAME_BITS{1'b0}};
                    lineBit  <= `ECS_STOP_LEVEL;
                end else if (!chanOn) begin
                    shiftReg <= {FRAME_BITS{1'b0}};
                    lineBit  <= `ECS_STOP_LEVEL;
                end else if (wordEdge) begin
                    shiftReg <= {`ECS_STOP_LEVEL,
                                 next_frame[FRAME_BITS-1:1]};
                    lineBit  <= next_frame[0];
                end else begin
                    shiftReg <= {`ECS_STOP_LEVEL,
                                 shiftReg[FRAME_BITS-1:1]};
                    lineBit  <= shiftReg[0];
                end
            end

            // every drive condition in one place; the sleeps are folded
            // into chanOn and the lock into runState
            assign driveOk = driveEnableSync
                             & runState
                             & chanOn & chanWake;

            // drive only when enabled, awake, locked and powered; the
            // shifter keeps running under drive enable low, so raising
            // it again shows the state the channel would have had
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    lineOe <= 1'b0;
                end else begin
                    lineOe <= driveOk;
                end
            end

            // outputs leave straight from flops
            assign serialLineOut[ch] = lineBit;
            assign serialLineOe[ch]  = lineOe;
            assign channelAwake[ch]  = chanWake;
            assign syncActive[ch]    = syncMode;
        end
    endgenerate

endmodule

//--- logic/ecs_consts.vh
`ifndef ECS_CONSTS_VH
`define ECS_CONSTS_VH

// channel count and word geometry
`define ECS_CHANNELS        8
`define ECS_DATA_BITS       10
`define ECS_FRAME_BITS      12
`define ECS_BIT_CNT_W       4

// frame framing bits, sent first and last
`define ECS_START_LEVEL     1'b1
`define ECS_STOP_LEVEL      1'b0

// sync pattern, sent lsb first: six ones then six zeros
`define ECS_SYNC_PATTERN    12'h03F

// word clock edges the resync request must be high before sync is sent
`define ECS_SYNC_HOLD_EDGES 3'h4
`define ECS_SYNC_CNT_W      3

// pll lock time in word clock periods
`define ECS_PLL_LOCK_EDGES  10'h1FE
`define ECS_PLL_CNT_W       10

// single channel wake time in word clock periods
`define ECS_CH_WAKE_EDGES   10'h03C

`endif

//--- logic/ecs_sync2.v
`timescale 1ns/1ns
// two flip-flop synchroniser for pin inputs; stage one feeds stage two only
module ecs_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stageOne;

    // both stages clear to zero so everything reads as asleep at reset
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stageOne <= {WIDTH{1'b0}};
            syncOut  <= {WIDTH{1'b0}};
        end else begin
            stageOne <= pinIn;
            syncOut  <= stageOne;
        end
    end

endmodule

//--- logic/ecs_lock_timer.v
`timescale 1ns/1ns
`include "ecs_consts.vh"
// counts word clock edges while enabled; reports done after LOCK_EDGES
module ecs_lock_timer #(
    parameter                     CNT_W      = `ECS_PLL_CNT_W,
    parameter [CNT_W-1:0]         LOCK_EDGES = `ECS_PLL_LOCK_EDGES
) (
    input  wire clk,
    input  wire rstn,
    input  wire enable,
    input  wire wordEdge,
    output reg  locked
);

    reg [CNT_W-1:0] edgeCount;

    // dropping enable restarts the whole lock sequence
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edgeCount <= {CNT_W{1'b0}};
            locked    <= 1'b0;
        end else if (!enable) begin
            edgeCount <= {CNT_W{1'b0}};
            locked    <= 1'b0;
        end else if (wordEdge && !locked) begin
            if (edgeCount == LOCK_EDGES - 1'b1) begin
                locked <= 1'b1;
            end
            edgeCount <= edgeCount + 1'b1;
        end
    end

endmodule

//--- dv/ecs_remote_rx.sv
`timescale 1ns/1ns
// far end receiver: hunts a 0-1 edge, then frames twelve bits
module ecs_remote_rx (
    input  wire        clk,
    input  wire        rstn,
    input  wire        lineIn,
    input  wire        lineOe,
    output reg  [11:0] frame,
    output reg  [15:0] frameCount
);
    reg [11:0] sh;
    reg [3:0]  idx;
    reg        hunt;
    reg        prev;
    // a bad clock bit drops lock; a misframed stream is accepted only while its data mimics the clock bits
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame <= 12'h000;
            frameCount <= 16'h0000;
            sh <= 12'h000;
            idx <= 4'h0;
            hunt <= 1'h1;
            prev <= 1'h0;
        end else begin
            prev <= lineIn;
            if (!lineOe) begin
                hunt <= 1'h1;
            end else if (hunt) begin
                if (lineIn && !prev) begin
                    hunt <= 1'h0;
                    idx <= 4'h1;
                    sh[0] <= 1'h1;
                end
            end else if (idx == 4'h0 && !lineIn) begin
                hunt <= 1'h1;
            end else if (idx == 4'hB) begin
                idx <= 4'h0;
                if (lineIn) begin
                    hunt <= 1'h1;
                end else begin
                    frame <= {1'h0, sh[10:0]};
                    frameCount <= frameCount + 16'h0001;
                end
            end else begin
                sh[idx] <= lineIn;
                idx <= idx + 4'h1;
            end
        end
    end
endmodule

//--- dv/ecs_serializer_chk.sv
`timescale 1ns/1ns
// watches the top ports; pin inputs reach outputs three clocks later
module ecs_serializer_chk #(
    parameter CHANNELS  = 8,
    parameter DATA_BITS = 10
) (
    input wire                          clk,
    input wire                          rstn,
    input wire                          sharedWordClock,
    input wire                          supplyGood,
    input wire                          masterSleepN,
    input wire [CHANNELS-1:0]           channelSleepN,
    input wire                          outputDriveEnable,
    input wire [CHANNELS-1:0]           resyncRequest,
    input wire [CHANNELS*DATA_BITS-1:0] parallelWordIn,
    input wire [CHANNELS-1:0]           serialLineOut,
    input wire [CHANNELS-1:0]           serialLineOe,
    input wire                          pllLocked,
    input wire [CHANNELS-1:0]           channelAwake,
    input wire [CHANNELS-1:0]           syncActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_lock_gates_oe:
        assert property (!pllLocked && !$past(pllLocked) |-> !serialLineOe)
        else $error("line driven without lock");
    chk_enable_floats:
        assert property (!outputDriveEnable [*4] |-> !serialLineOe)
        else $error("line driven with enable low");
    chk_master_floats:
        assert property (!masterSleepN [*4] |-> !serialLineOe && !pllLocked)
        else $error("master sleep did not stop");
    chk_supply_floats:
        assert property (!supplyGood [*4] |-> !serialLineOe && !pllLocked)
        else $error("running without supply good");
    chk_sleep_floats:
        assert property (!channelSleepN[1] [*4] |-> !serialLineOe[1])
        else $error("sleeping channel driven");
    chk_sync_shape:
        assert property ($rose(syncActive[0]) |->
            serialLineOut[0] [*6] ##1 !serialLineOut[0] [*6])
        else $error("bad sync pattern");
    chk_lock_kept:
        assert property ((pllLocked && masterSleepN && supplyGood) [*3]
            |=> pllLocked)
        else $error("lock lost while powered");
    chk_sync_clear:
        assert property (!resyncRequest[0] [*4] |-> !syncActive[0])
        else $error("sync kept after request low");
endmodule

bind ecs_serializer ecs_serializer_chk #(
    .CHANNELS(CHANNELS), .DATA_BITS(DATA_BITS)) chk_i (
    .clk(clk), .rstn(rstn), .sharedWordClock(sharedWordClock),
    .supplyGood(supplyGood), .masterSleepN(masterSleepN),
    .channelSleepN(channelSleepN), .outputDriveEnable(outputDriveEnable),
    .resyncRequest(resyncRequest), .parallelWordIn(parallelWordIn),
    .serialLineOut(serialLineOut), .serialLineOe(serialLineOe),
    .pllLocked(pllLocked), .channelAwake(channelAwake),
    .syncActive(syncActive));

//--- dv/ecs_serializer_bench.sv
`timescale 1ns/1ns
module ecs_serializer_bench;
    reg         clk = 1'h0;
    reg         rstn = 1'h0;
    reg         sharedWordClock = 1'h0;
    reg         supplyGood = 1'h0;
    reg         masterSleepN = 1'h1;
    reg  [7:0]  channelSleepN = 8'hFF;
    reg         outputDriveEnable = 1'h1;
    reg  [7:0]  resyncRequest = 8'h00;
    reg  [79:0] parallelWordIn = 80'h0;
    wire [7:0]  serialLineOut;
    wire [7:0]  serialLineOe;
    wire [7:0]  channelAwake;
    wire [7:0]  syncActive;
    wire        pllLocked;
    wire [11:0] frame;
    wire [15:0] frameCount;
    reg  [9:0]  w;
    integer     num_errors = 0;
    integer     cmp_count = 0;
    integer     wcnt = 0;
    integer     i;
    time        t0;
    // bit clock and a free running word clock of twelve bit times
    always #5 clk = ~clk;
    always @(posedge clk) begin
        wcnt <= (wcnt == 11) ? 0 : wcnt + 1;
        sharedWordClock <= (wcnt < 6);
    end
    ecs_serializer dut (.clk(clk), .rstn(rstn),
        .sharedWordClock(sharedWordClock), .supplyGood(supplyGood),
        .masterSleepN(masterSleepN), .channelSleepN(channelSleepN),
        .outputDriveEnable(outputDriveEnable), .resyncRequest(resyncRequest),
        .parallelWordIn(parallelWordIn), .serialLineOut(serialLineOut),
        .serialLineOe(serialLineOe), .pllLocked(pllLocked),
        .channelAwake(channelAwake), .syncActive(syncActive));
    ecs_remote_rx rx (.clk(clk), .rstn(rstn), .lineIn(serialLineOut[0]),
        .lineOe(serialLineOe[0]), .frame(frame), .frameCount(frameCount));
    task check(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: seen %h expected %h",
                    $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (num_errors == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // waits for n more whole frames at the far end, then lets outputs settle
    task frames(input integer n);
        integer k;
        reg [15:0] tgt;
        begin
            tgt = frameCount + n[15:0];
            for (k = 0; k < 40 * n && frameCount !== tgt; k = k + 1)
                @(posedge clk);
            if (frameCount !== tgt) begin
                num_errors = num_errors + 1;
                wrap_up;
            end
            #1;
        end
    endtask
    // lock plus channel wake is long, so poll the enables with a bound
    task ready;
        integer k;
        begin
            for (k = 0; k < 9000 && serialLineOe !== 8'hFF; k = k + 1)
                @(posedge clk);
            if (serialLineOe !== 8'hFF) begin
                num_errors = num_errors + 1;
                wrap_up;
            end
            #1 check(pllLocked, 16'h1);
            check(channelAwake, 16'hFF);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        repeat (40) @(posedge clk);
        #1 check(pllLocked, 16'h0);
        check(serialLineOe, 16'h0);
        @(posedge clk) supplyGood <= 1'h1;
        ready;
        // alternating, then all ones, end bits only, all zeros
        for (i = 0; i < 4; i = i + 1) begin
            w = (i == 0) ? 10'h155 : (i == 1) ? 10'h3FF :
                (i == 2) ? 10'h201 : 10'h000;
            @(posedge clk) parallelWordIn <= {8{w}};
            frames(3);
            check(frame, {1'h0, w, 1'h1});
            t0 = $time;
            frames(2);
            check(16'(($time - t0) / 10), 16'h18);
        end
        @(posedge clk) resyncRequest <= 8'h01;
        frames(2);
        check(syncActive, 16'h0);
        frames(6);
        check(syncActive, 16'h1);
        check(frame, 16'h03F);
        w = 10'h0F0;
        @(posedge clk) parallelWordIn <= {8{w}};
        resyncRequest <= 8'h00;
        frames(3);
        check(syncActive, 16'h0);
        check(frame, {1'h0, w, 1'h1});
        @(posedge clk) channelSleepN <= 8'hFD;
        repeat (6) @(posedge clk);
        #1 check(serialLineOe, 16'hFD);
        check(pllLocked, 16'h1);
        @(posedge clk) channelSleepN <= 8'hFF;
        repeat (690) @(posedge clk);
        #1 check(serialLineOe, 16'hFD);
        repeat (80) @(posedge clk);
        #1 check(serialLineOe, 16'hFF);
        @(posedge clk) outputDriveEnable <= 1'h0;
        parallelWordIn <= 80'h0;
        repeat (6) @(posedge clk);
        #1 check(serialLineOe, 16'h0);
        @(posedge clk) outputDriveEnable <= 1'h1;
        frames(3);
        check(serialLineOe, 16'hFF);
        check(frame, 16'h001);
        @(posedge clk) masterSleepN <= 1'h0;
        repeat (6) @(posedge clk);
        #1 check(serialLineOe, 16'h0);
        check(pllLocked, 16'h0);
        @(posedge clk) masterSleepN <= 1'h1;
        ready;
        frames(3);
        check(frame, 16'h001);
        wrap_up;
    end
endmodule
